// ===== src/hhdlw_top.sv
// display line writer: AXI4-Lite register front end and line write engine
// assumes one 25 MHz clock and a display panel that takes one char a cycle
//
// Behaviour
// [RQ1] bits 1:0 of control byte pick display line one to four
// [RQ2] at most sixteen characters are taken and shown per line write
// [RQ3] character bytes m+4..m+19 map rightmost to leftmost position
// [RQ4] software selects line, loads chars, sets request, waits, clears
// [RQ5] on request the line is written, then acknowledge bit 7 rises
// [RQ6] software drops its request after it sees the acknowledge
// [RQ7] withdrawn request clears acknowledge, readying the next line write
// [RQ8] codes 20H to 7FH are shown as standard characters
// [RQ9] codes A0H to FFH are shown as special characters
// [RQ10] software keeps selection and chars stable while request is up
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "hhdlw_defs.svh"

module hhdlw_top
  import hhdlw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`HHDLW_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`HHDLW_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output hhdlw_disp_t disp
);

  // register state
  logic [7:0] ctrl_r;
  logic [7:0] chars_r [`HHDLW_CHARS];
  logic ack_r;
  logic [1:0] last_line_r;
  hhdlw_state_t state_r;
  logic [3:0] col_r;
  logic [1:0] line_r;

  // write channel holding
  logic aw_full_r;
  logic w_full_r;
  logic [`HHDLW_ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  wire logic aw_take;
  wire logic w_take;
  wire logic b_done;
  wire logic do_write;
  wire logic [`HHDLW_ADDR_W-1:0] wr_word;
  wire logic wr_ctrl;
  wire logic wr_char;
  wire logic wr_stat;
  wire logic [1:0] wr_char_idx;
  wire logic wr_mapped;
  wire logic [7:0] wr_sub;
  wire logic [7:0] ctrl_nxt;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign b_done = s_axi_bvalid && s_axi_bready;
  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_word = {aw_addr_r[`HHDLW_ADDR_W-1:2], 2'b00};
  assign wr_ctrl = (wr_word == `HHDLW_CTRL_OFF);
  assign wr_char = (wr_word >= `HHDLW_CHAR0_OFF) &&
                   (wr_word <= `HHDLW_CHAR3_OFF);
  assign wr_stat = (wr_word == `HHDLW_STAT_OFF);
  assign wr_mapped = wr_ctrl || wr_char || wr_stat;
  assign wr_sub = wr_word - `HHDLW_CHAR0_OFF;
  assign wr_char_idx = wr_sub[3:2];
  assign ctrl_nxt = w_strb_r[0] ? w_data_r[7:0] : ctrl_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (b_done) begin
      s_axi_awready <= 1'b1;
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      w_full_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (b_done) begin
      s_axi_wready <= 1'b1;
      w_full_r <= 1'b0;
    end
  end

  // status is read only: a write there is accepted and ignored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HHDLW_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? `HHDLW_RESP_OKAY : `HHDLW_RESP_SLVERR;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `HHDLW_CTRL_RST;
    end else if (do_write && wr_ctrl) begin
      ctrl_r <= ctrl_nxt; // [RQ1]
    end
  end

  // byte j of char word k is position 4k+j; position 0 is rightmost
  genvar gk, gj;
  generate
    for (gk = 0; gk < `HHDLW_CHAR_WORDS; gk++) begin : g_word
      for (gj = 0; gj < 4; gj++) begin : g_byte
        always_ff @(posedge core_clk or posedge rst) begin
          if (rst) begin
            chars_r[gk*4+gj] <= `HHDLW_BLANK;
          end else if (do_write && wr_char && (wr_char_idx == gk) &&
                       w_strb_r[gj]) begin
            chars_r[gk*4+gj] <= w_data_r[gj*8 +: 8]; // [RQ3]
          end
        end
      end
    end
  endgenerate

  // line write engine
  wire logic req;
  hhdlw_cls_t cur_cls;
  wire logic [7:0] cur_code;

  assign req = ctrl_r[`HHDLW_REQ_BIT];

  // chars are read live during the write; software keeps them still
  hhdlw_char_class u_class (
    .code_in(chars_r[col_r]), // [RQ10]
    .cls(cur_cls),
    .code_out(cur_code)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= HHDLW_IDLE;
      col_r <= '0;
      line_r <= '0;
      last_line_r <= '0;
      ack_r <= 1'b0;
      disp <= '0;
    end else begin
      disp.we <= 1'b0;
      unique case (state_r)
        HHDLW_IDLE: begin
          if (req) begin
            state_r <= HHDLW_WRITE;
            line_r <= ctrl_r[`HHDLW_SEL_MSB:`HHDLW_SEL_LSB]; // [RQ1]
            col_r <= '0;
          end
        end
        HHDLW_WRITE: begin
          disp.we <= 1'b1;
          disp.line <= line_r;
          disp.col <= col_r; // [RQ3]
          disp.code <= cur_code;
          disp.special <= (cur_cls == HHDLW_CLS_SPC); // [RQ9]
          col_r <= col_r + 4'h1;
          // stop after the sixteenth position, never wrap to a 17th
          if (col_r == `HHDLW_LAST_COL) begin // [RQ2]
            state_r <= HHDLW_ACKED;
            ack_r <= 1'b1; // [RQ5]
            last_line_r <= line_r;
          end
        end
        HHDLW_ACKED: begin
          if (!req) begin // [RQ6]
            ack_r <= 1'b0; // [RQ7]
            state_r <= HHDLW_IDLE;
          end
        end
        // the spare state code would otherwise lock the engine up
        default: begin
          state_r <= HHDLW_IDLE;
        end
      endcase
    end
  end

  // read channel: answer one cycle after the address is taken
  wire logic ar_take;
  wire logic [`HHDLW_ADDR_W-1:0] rd_word;
  wire logic [7:0] rd_sub;
  wire logic rd_char;
  wire logic [1:0] rd_char_idx;
  wire logic [31:0] stat_word;
  wire logic [31:0] char_word;
  wire logic [31:0] rd_data;
  wire logic rd_mapped;

  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_word = {s_axi_araddr[`HHDLW_ADDR_W-1:2], 2'b00};
  assign rd_sub = rd_word - `HHDLW_CHAR0_OFF;
  assign rd_char_idx = rd_sub[3:2];
  assign rd_char = (rd_word >= `HHDLW_CHAR0_OFF) &&
                   (rd_word <= `HHDLW_CHAR3_OFF);
  assign char_word = {chars_r[{rd_char_idx, 2'd3}],
                      chars_r[{rd_char_idx, 2'd2}],
                      chars_r[{rd_char_idx, 2'd1}],
                      chars_r[{rd_char_idx, 2'd0}]};
  assign stat_word = (32'(ack_r) << `HHDLW_ACK_BIT) |
                     (32'(state_r != HHDLW_IDLE) << `HHDLW_BUSY_BIT) |
                     (32'(last_line_r) << `HHDLW_LAST_LSB);
  assign rd_mapped = (rd_word == `HHDLW_CTRL_OFF) || rd_char ||
                     (rd_word == `HHDLW_STAT_OFF);
  assign rd_data = (rd_word == `HHDLW_CTRL_OFF) ? {24'h000000, ctrl_r} :
                   rd_char ? char_word :
                   (rd_word == `HHDLW_STAT_OFF) ? stat_word : 32'h00000000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `HHDLW_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_mapped ? `HHDLW_RESP_OKAY : `HHDLW_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : hhdlw_top
`default_nettype wire

// ===== src/hhdlw_defs.svh
// offsets, field positions, reset values and counts for the display line
// writer; assumes an AXI4-Lite slave with 32-bit data and byte addressing
`ifndef HHDLW_DEFS_SVH
`define HHDLW_DEFS_SVH

`define HHDLW_ADDR_W 8
`define HHDLW_CTRL_OFF 8'h00
`define HHDLW_CHAR0_OFF 8'h04
`define HHDLW_CHAR3_OFF 8'h10
`define HHDLW_STAT_OFF 8'h14

`define HHDLW_SEL_LSB 0
`define HHDLW_SEL_MSB 1
`define HHDLW_REQ_BIT 7
`define HHDLW_ACK_BIT 7
`define HHDLW_BUSY_BIT 0
`define HHDLW_LAST_LSB 2
`define HHDLW_LAST_MSB 3

`define HHDLW_CHARS 16
`define HHDLW_CHAR_WORDS 4
`define HHDLW_LAST_COL 4'hF
`define HHDLW_STD_LO 8'h20
`define HHDLW_STD_HI 8'h7F
`define HHDLW_SPC_LO 8'hA0
`define HHDLW_BLANK 8'h20
`define HHDLW_CTRL_RST 8'h00

`define HHDLW_RESP_OKAY 2'h0
`define HHDLW_RESP_SLVERR 2'h2

`endif

// ===== src/hhdlw_pkg.sv
// types shared by the display line writer modules
// assumes hhdlw_defs.svh supplies the numeric constants
package hhdlw_pkg;

  typedef enum logic [1:0] {
    HHDLW_CLS_STD,
    HHDLW_CLS_SPC,
    HHDLW_CLS_BAD
  } hhdlw_cls_t;

  typedef enum logic [1:0] {
    HHDLW_IDLE,
    HHDLW_WRITE,
    HHDLW_ACKED
  } hhdlw_state_t;

  // one character write toward the display panel
  typedef struct packed {
    logic we;
    logic [1:0] line;
    logic [3:0] col;
    logic [7:0] code;
    logic special;
  } hhdlw_disp_t;

endpackage : hhdlw_pkg

// ===== src/hhdlw_char_class.sv
// classifies one character code into standard, special or undisplayable
// assumes a byte from the same clock domain; purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "hhdlw_defs.svh"

module hhdlw_char_class
  import hhdlw_pkg::*;
(
  input wire logic [7:0] code_in,
  output hhdlw_cls_t cls,
  output logic [7:0] code_out
);

  wire logic is_std;
  wire logic is_spc;

  assign is_std = (code_in >= `HHDLW_STD_LO) && (code_in <= `HHDLW_STD_HI); // [RQ8]
  assign is_spc = (code_in >= `HHDLW_SPC_LO); // [RQ9]
  assign cls = is_std ? HHDLW_CLS_STD :
               (is_spc ? HHDLW_CLS_SPC : HHDLW_CLS_BAD);
  // codes outside both ranges have no glyph, so they show as a blank
  assign code_out = (is_std || is_spc) ? code_in : `HHDLW_BLANK;

endmodule : hhdlw_char_class
`default_nettype wire

// ===== sim/hhdlw_asserts.sv
// port checker for the display line writer
// assumes binding onto hhdlw_top, one clock, async high reset
`timescale 1ns/10ps
`default_nettype none
module hhdlw_asserts
  import hhdlw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire hhdlw_disp_t disp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_mid;
    disp.we && disp.col != 4'hF;
  endsequence
  a_col_step: assert property (s_mid |=>
    disp.we && disp.col == $past(disp.col) + 4'h1) else $error("col order");
  a_line_end: assert property (disp.we && disp.col == 4'hF |=> !disp.we)
    else $error("extra char");
  a_sweep_start: assert property ($rose(disp.we) |-> disp.col == 4'h0)
    else $error("bad first col");
  a_line_hold: assert property (s_mid |=> $stable(disp.line))
    else $error("line moved");
  a_std_plain: assert property (disp.we && disp.code <= 8'h7F |->
    !disp.special) else $error("std flagged");
  a_spc_flag: assert property (disp.we && disp.code >= 8'hA0 |->
    disp.special) else $error("spc unflagged");
  a_code_shown: assert property (disp.we |-> disp.code >= 8'h20 &&
    !(disp.code inside {[8'h80:8'h9F]})) else $error("bad code");
endmodule : hhdlw_asserts
bind hhdlw_top hhdlw_asserts i_chk (.core_clk(core_clk), .rst(rst),
  .disp(disp));
`default_nettype wire

// ===== sim/hhdlw_panel.sv
// display panel model: keeps what each char pulse wrote
// assumes one char pulse a cycle from the line writer
`timescale 1ns/10ps
`default_nettype none
module hhdlw_panel
  import hhdlw_pkg::*;
(
  input wire logic core_clk,
  input wire hhdlw_disp_t disp
);
  logic [7:0] mem [4][16];
  logic spc [4][16];
  int n_we = 0;
  always @(posedge core_clk) begin
    if (disp.we) begin
      mem[disp.line][disp.col] <= disp.code;
      spc[disp.line][disp.col] <= disp.special;
      n_we <= n_we + 1;
    end
  end
endmodule : hhdlw_panel
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the display line writer
// assumes 25 MHz clock and the AXI4-Lite map of hhdlw_defs.svh
`timescale 1ns/10ps
`default_nettype none
module testbench
  import hhdlw_pkg::*;
;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire hhdlw_disp_t disp;
  int n_errors = 0;
  int n_checks = 0;
  // boundary codes of both ranges and of the gaps, plus the mid-range code 41H
  logic [7:0] tbl [8] = '{8'h20, 8'h7F, 8'hA0, 8'hFF, 8'h1F, 8'h80,
    8'h9F, 8'h41};
  always #20 core_clk = ~core_clk;
  hhdlw_top i_dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .disp(disp));
  hhdlw_panel i_panel (.core_clk(core_clk), .disp(disp));
  task wrap_up;
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task bound(input logic ok);
    if (!ok) begin
      n_errors++;
      wrap_up();
    end
  endtask : bound
  // ready is a register, so its value at the falling edge is the one
  // the next rising edge sees
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    bh = 1'h0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int i = 0; i < 40 && !bh; i++) begin
      @(negedge core_clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r = bresp;
      @(posedge core_clk);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
      if (bh) bready <= 1'h0;
    end
    bound(bh);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    rh = 1'h0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int i = 0; i < 40 && !rh; i++) begin
      @(negedge core_clk);
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ah) arvalid <= 1'h0;
      if (rh) rready <= 1'h0;
    end
    bound(rh);
  endtask : rd
  task t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h00, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h0);
    rd(8'h10, d, r);
    chk(d, 32'h20202020);
    rd(8'h14, d, r);
    chk(d, 32'h0);
  endtask : t_reset
  task t_lines;
    logic [31:0] d, w;
    logic [1:0] r;
    logic [7:0] c, e;
    int k;
    for (int l = 0; l < 4; l++) begin
      for (k = 0; k < 4; k++) begin
        for (int j = 0; j < 4; j++) w[8*j +: 8] = tbl[(4*k + j + l) % 8];
        wr(8'h04 + 8'(4 * k), w, r);
      end
      wr(8'h00, 32'h80 | 32'(l), r);
      chk({30'h0, r}, 32'h0);
      d = 32'h0;
      for (k = 0; k < 60 && !d[7]; k++) rd(8'h14, d, r);
      bound(d[7]);
      chk(32'(i_panel.n_we), 32'(16 * (l + 1)));
      chk({30'h0, d[3:2]}, 32'(l));
      for (int p = 0; p < 16; p++) begin
        c = tbl[(p + l) % 8];
        e = (c < 8'h20 || (c >= 8'h80 && c < 8'hA0)) ? 8'h20 : c;
        chk({24'h0, i_panel.mem[l][p]}, {24'h0, e});
        chk({31'h0, i_panel.spc[l][p]}, {31'h0, c >= 8'hA0});
      end
      wr(8'h00, 32'(l), r);
      for (k = 0; k < 10 && d[7]; k++) rd(8'h14, d, r);
      chk({31'h0, d[7]}, 32'h0);
    end
  endtask : t_lines
  task t_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h18, 32'hFFFFFFFF, r);
    chk({30'h0, r}, 32'h2);
    rd(8'h18, d, r);
    chk({d[31:2], r}, 32'h2);
    wr(8'h14, 32'hFF, r);
    rd(8'h14, d, r);
    chk(d, 32'hC);
  endtask : t_unmapped
  // lanes whose strobe is low must keep their old bytes
  task t_strobe;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h04, 32'h11223344, r);
    wstrb <= 4'h2;
    wr(8'h04, 32'hAABBCCDD, r);
    rd(8'h04, d, r);
    chk(d, 32'h1122CC44);
    wstrb <= 4'hE;
    wr(8'h00, 32'h00000083, r);
    chk({30'h0, r}, 32'h0);
    wstrb <= 4'hF;
    rd(8'h00, d, r);
    chk(d, 32'h3);
    rd(8'h14, d, r);
    chk(d, 32'hC);
  endtask : t_strobe
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    t_reset();
    t_lines();
    t_unmapped();
    t_strobe();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
